// ===== hw/efp_fifo.sv
// Purpose: lookahead fifo on one memory primitive with ecc and output pipeline
// Assumes: user logic on sys_clk_in; wr and rd sides share that clock
// Notes:   pointers still cross through gray stages, so flags are pessimistic
// Operation
// RULE1: lookahead data and valid pass one extra always-on pipeline register
// RULE2: output pipeline offered only with a single primitive in depth
// RULE3: read data register loads a set reset value; the code loads it only when ecc is off
// RULE4: ecc available only for this memory primitive build, either clocking
// RULE5: encode on write, decode on read, report none, single or double
// RULE6: single error corrected at output, stored word left as is
// RULE7: each error flag is the or of all primitive flags
// RULE8: user must not tie error flags to the word being read
// RULE9: on double error user stops, resets fifo, restarts transfer
// RULE10: error flags are combinational, not registered
// RULE11: write-side error flags synchronised before combining with read side
// RULE12: injection inputs act only with ecc and injection enabled
// RULE13: single injection corrupts one bit so single flag rises on read
// RULE14: double injection corrupts two bits so double flag rises on read
// RULE15: both injection inputs high gives a double-bit error
// RULE16: code spans 64-bit words; spare bits included in the check
// RULE17: with ecc, reset leaves read data and error flags untouched
// RULE18: correct for any frequency and phase between the two sides
// RULE19: each port belongs to its write or read side
// RULE20: binary pointers, gray for crossing, flags from synced pointers
// RULE21: empty release latency depends on crossing delay
// RULE22: each ecc primitive holds 512 entries; deeper requests cascade
// RULE23: accepted write and level step only on enable with not full
// RULE24: underflow asserts on read enable while empty
// RULE25: each gray pointer passes two receiving flip-flops before use
`timescale 1ns/1ps
module efp_fifo #(
  parameter bit ECC_EN = 1'b1,
  parameter bit INJ_EN = 1'b1
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       ce_in,
  input  wire logic [efp_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                       wr_en_in,
  input  wire logic                       inject_sbit_in,
  input  wire logic                       inject_dbit_in,
  output logic                            full_out,
  output logic                            almost_full_out,
  output logic                            wr_ack_out,
  output logic                            overflow_out,
  output logic      [efp_pkg::PTR_W-1:0]  wr_level_out,
  input  wire logic                       rd_en_in,
  output logic      [efp_pkg::DATA_W-1:0] rd_data_out,
  output logic                            valid_out,
  output logic                            empty_out,
  output logic                            almost_empty_out,
  output logic                            underflow_out,
  output logic                            sbit_err_out,
  output logic                            dbit_err_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [efp_pkg::PTR_W-1:0]  wr_ptr;
    logic [efp_pkg::PTR_W-1:0]  rd_ptr;
    logic [efp_pkg::PTR_W-1:0]  wr_gray;
    logic [efp_pkg::PTR_W-1:0]  rd_gray;
    logic [efp_pkg::PTR_W-1:0]  wr_gray_s1;
    logic [efp_pkg::PTR_W-1:0]  wr_gray_s2;
    logic [efp_pkg::PTR_W-1:0]  rd_gray_s1;
    logic [efp_pkg::PTR_W-1:0]  rd_gray_s2;
    logic [efp_pkg::CODE_W-1:0] mem_q;
    logic                       mem_q_vld;
    logic                       flag_vld;
    logic [efp_pkg::DATA_W-1:0] dout;
    logic                       vld;
    logic                       empty;
    logic                       aempty;
    logic                       udf;
    logic                       full;
    logic                       afull;
    logic                       wr_ack;
    logic                       ovf;
    logic [efp_pkg::PTR_W-1:0]  wr_lvl;
    logic [1:0]                 werr;
    logic [1:0]                 werr_s1;
    logic [1:0]                 werr_s2;
  } efp_st_s;

  efp_st_s st_reg;
  efp_st_s st_next;

  logic [efp_pkg::CODE_W-1:0] mem_arr [efp_pkg::PRIM_DEPTH];

  logic [efp_pkg::CODE_W-1:0] enc_code;
  logic [efp_pkg::CODE_W-1:0] wr_code;
  logic [efp_pkg::PRIM_W-1:0] dec_data;
  logic                       dec_sbe;
  logic                       dec_dbe;
  logic                       chk_sbe;
  logic                       chk_dbe;
  logic                       wr_acc;
  logic                       inj_s;
  logic                       inj_d;
  logic                       s2_take;
  logic                       s1_load;
  logic [efp_pkg::PTR_W-1:0]  avail;
  logic [efp_pkg::PTR_W-1:0]  occ;

  // ---------------------------------------------------------------------------
  // ecc codec and write path
  // ---------------------------------------------------------------------------
  // spare bits above the user width are zero but still coded
  efp_secded u_codec (
    .enc_data_in  ({{(efp_pkg::PRIM_W - efp_pkg::DATA_W){1'b0}}, wr_data_in}), // RULE16
    .enc_code_out (enc_code),
    .dec_code_in  (st_reg.mem_q),
    .dec_data_out (dec_data),
    .dec_sbe_out  (dec_sbe),
    .dec_dbe_out  (dec_dbe)
  );

  // write-side check of the freshly coded word
  efp_secded u_wchk (
    .enc_data_in  ('0),
    .enc_code_out (),
    .dec_code_in  (enc_code),
    .dec_data_out (),
    .dec_sbe_out  (chk_sbe),
    .dec_dbe_out  (chk_dbe)
  );

  assign wr_acc = wr_en_in && !st_reg.full; // RULE23
  assign inj_s  = ECC_EN && INJ_EN && inject_sbit_in && !inject_dbit_in; // RULE12 RULE15
  assign inj_d  = ECC_EN && INJ_EN && inject_dbit_in; // RULE12 RULE15

  always_comb begin
    wr_code = enc_code; // RULE5
    if (inj_d) begin
      wr_code[efp_pkg::INJ_BIT_A] = ~enc_code[efp_pkg::INJ_BIT_A]; // RULE14
      wr_code[efp_pkg::INJ_BIT_B] = ~enc_code[efp_pkg::INJ_BIT_B]; // RULE14
    end else if (inj_s) begin
      wr_code[efp_pkg::INJ_BIT_A] = ~enc_code[efp_pkg::INJ_BIT_A]; // RULE13
    end
  end

  // one primitive of 512 words; reads never write corrections back
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && wr_acc) begin
      mem_arr[st_reg.wr_ptr[efp_pkg::ADDR_W-1:0]] <= wr_code; // RULE6 RULE22 RULE2
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  assign avail   = efp_pkg::gray2bin(st_reg.wr_gray_s2) - st_reg.rd_ptr; // RULE20 RULE21
  assign s2_take = !st_reg.vld || rd_en_in;
  assign s1_load = (avail != '0) && (!st_reg.mem_q_vld || s2_take);

  always_comb begin
    st_next = st_reg;
    // write side
    if (wr_acc) begin
      st_next.wr_ptr = st_reg.wr_ptr + 10'h001; // RULE23
    end
    st_next.wr_gray    = efp_pkg::bin2gray(st_next.wr_ptr); // RULE20
    st_next.rd_gray_s1 = st_reg.rd_gray; // RULE25 RULE18
    st_next.rd_gray_s2 = st_reg.rd_gray_s1; // RULE25
    st_next.wr_lvl     = st_next.wr_ptr - efp_pkg::gray2bin(st_reg.rd_gray_s2); // RULE20
    st_next.full       = st_next.wr_lvl == efp_pkg::DEPTH_LVL;
    st_next.afull      = st_next.wr_lvl >= efp_pkg::AFULL_LVL;
    st_next.wr_ack     = wr_acc; // RULE23
    st_next.ovf        = wr_en_in && st_reg.full;
    st_next.werr       = {chk_dbe, chk_sbe};
    // read side: primitive latch, then output pipeline stage
    if (s1_load) begin
      st_next.mem_q     = mem_arr[st_reg.rd_ptr[efp_pkg::ADDR_W-1:0]];
      st_next.mem_q_vld = 1'b1;
      st_next.rd_ptr    = st_reg.rd_ptr + 10'h001;
    end else if (s2_take) begin
      st_next.mem_q_vld = 1'b0;
    end
    if (s2_take) begin
      st_next.vld = st_reg.mem_q_vld; // RULE1
      if (st_reg.mem_q_vld) begin
        st_next.dout = dec_data[efp_pkg::DATA_W-1:0]; // RULE1 RULE6
      end
    end
    st_next.rd_gray    = efp_pkg::bin2gray(st_next.rd_ptr); // RULE20
    st_next.wr_gray_s1 = st_reg.wr_gray; // RULE25 RULE18
    st_next.wr_gray_s2 = st_reg.wr_gray_s1; // RULE25
    st_next.werr_s1    = st_reg.werr; // RULE11
    st_next.werr_s2    = st_reg.werr_s1; // RULE11
    st_next.empty      = !st_next.vld;
    st_next.aempty     = !(st_next.vld && st_next.mem_q_vld);
    st_next.flag_vld   = st_next.mem_q_vld; // RULE17
    st_next.udf        = rd_en_in && st_reg.empty; // RULE24
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg.wr_ptr     <= efp_pkg::PTR_RST;
      st_reg.rd_ptr     <= efp_pkg::PTR_RST;
      st_reg.wr_gray    <= efp_pkg::PTR_RST;
      st_reg.rd_gray    <= efp_pkg::PTR_RST;
      st_reg.wr_gray_s1 <= efp_pkg::PTR_RST;
      st_reg.wr_gray_s2 <= efp_pkg::PTR_RST;
      st_reg.rd_gray_s1 <= efp_pkg::PTR_RST;
      st_reg.rd_gray_s2 <= efp_pkg::PTR_RST;
      st_reg.vld        <= 1'b0;
      st_reg.empty      <= 1'b1;
      st_reg.aempty     <= 1'b1;
      st_reg.udf        <= 1'b0;
      st_reg.full       <= 1'b0;
      st_reg.afull      <= 1'b0;
      st_reg.wr_ack     <= 1'b0;
      st_reg.ovf        <= 1'b0;
      st_reg.wr_lvl     <= efp_pkg::PTR_RST;
      st_reg.mem_q_vld  <= 1'b0;
      if (!ECC_EN) begin
        st_reg.dout      <= efp_pkg::DOUT_RST_VAL; // RULE3
        st_reg.mem_q     <= '0;
        st_reg.flag_vld  <= 1'b0;
        st_reg.werr      <= 2'h0;
        st_reg.werr_s1   <= 2'h0;
        st_reg.werr_s2   <= 2'h0;
      end
      // with ecc, data and error sources hold through reset
    end else if (ce_in) begin
      st_reg <= st_next; // RULE17
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign full_out         = st_reg.full;
  assign almost_full_out  = st_reg.afull;
  assign wr_ack_out       = st_reg.wr_ack;
  assign overflow_out     = st_reg.ovf;
  assign wr_level_out     = st_reg.wr_lvl;
  assign rd_data_out      = st_reg.dout;
  assign valid_out        = st_reg.vld;
  assign empty_out        = st_reg.empty;
  assign almost_empty_out = st_reg.aempty;
  assign underflow_out    = st_reg.udf;
  // flags: or of read primitive and synced write-side flags, unregistered
  assign sbit_err_out = ECC_EN && // RULE4 RULE7 RULE10 RULE11
                        ((st_reg.flag_vld && dec_sbe) || st_reg.werr_s2[0]);
  assign dbit_err_out = ECC_EN && // RULE4 RULE7 RULE10 RULE11
                        ((st_reg.flag_vld && dec_dbe) || st_reg.werr_s2[1]);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  assign occ = st_reg.wr_ptr - st_reg.rd_ptr;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_ack;
    ce_in && wr_en_in && !full_out |=>
      wr_ack_out && (st_reg.wr_ptr == $past(st_reg.wr_ptr) + 10'h001);
  endproperty
  a_ack: assert property (p_ack) else $error("accepted write not counted"); // RULE23

  property p_ovf;
    ce_in && wr_en_in && full_out |=> overflow_out && !wr_ack_out;
  endproperty
  a_ovf: assert property (p_ovf) else $error("write while full was taken"); // RULE23

  property p_udf;
    ce_in && rd_en_in && empty_out |=> underflow_out;
  endproperty
  a_udf: assert property (p_udf) else $error("underflow not flagged"); // RULE24

  property p_pipe;
    ce_in && !valid_out && st_reg.mem_q_vld |=>
      valid_out && (rd_data_out == $past(dec_data[efp_pkg::DATA_W-1:0]));
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline stage did not load"); // RULE1

  property p_wsync;
    ce_in ##1 ce_in |=> st_reg.wr_gray_s2 == $past(st_reg.wr_gray, 2);
  endproperty
  a_wsync: assert property (p_wsync) else $error("write pointer sync depth wrong"); // RULE25

  property p_rsync;
    ce_in ##1 ce_in |=> st_reg.rd_gray_s2 == $past(st_reg.rd_gray, 2);
  endproperty
  a_rsync: assert property (p_rsync) else $error("read pointer sync depth wrong"); // RULE25

  property p_occ;
    occ <= efp_pkg::DEPTH_LVL;
  endproperty
  a_occ: assert property (p_occ) else $error("memory overfilled"); // RULE20

  property p_sor;
    ECC_EN && st_reg.mem_q_vld && dec_sbe |-> sbit_err_out;
  endproperty
  a_sor: assert property (p_sor) else $error("single error not reported"); // RULE7

  property p_dor;
    ECC_EN && st_reg.werr_s2[1] |-> dbit_err_out;
  endproperty
  a_dor: assert property (p_dor) else $error("write-side double error lost"); // RULE11

endmodule

// ===== common/efp_pkg.sv
// Purpose: shared constants and helpers for the ecc fifo with output pipeline
// Assumes: one primitive in depth, 64-bit code data word, secded (72,64) code
// Notes:   pointer helpers are used on both sides of the pointer crossing
package efp_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int PRIM_W     = 64;
  localparam int CODE_W     = 72;
  localparam int PAR_N      = 7;
  localparam int PRIM_DEPTH = 512;
  localparam int DEPTH      = PRIM_DEPTH;
  localparam int ADDR_W     = 9;
  localparam int PTR_W      = 10;

  // ---------------------------------------------------------------------------
  // fixed values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] DOUT_RST_VAL = 16'h0000;
  localparam logic [PTR_W-1:0]  DEPTH_LVL    = 10'h200;
  localparam logic [PTR_W-1:0]  AFULL_LVL    = 10'h1ff;
  localparam logic [PTR_W-1:0]  PTR_RST      = 10'h000;
  localparam int                INJ_BIT_A    = 3;
  localparam int                INJ_BIT_B    = 5;

  // ---------------------------------------------------------------------------
  // pointer code conversion
  // ---------------------------------------------------------------------------
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ===== hw/efp_secded.sv
// Purpose: secded (72,64) encoder and decoder for one memory primitive word
// Assumes: bit 0 is overall parity, parity bits at power-of-two positions
// Notes:   purely combinational; decoder corrects one bit, flags two
`timescale 1ns/1ps
module efp_secded (
  input  wire logic [efp_pkg::PRIM_W-1:0] enc_data_in,
  output logic      [efp_pkg::CODE_W-1:0] enc_code_out,
  input  wire logic [efp_pkg::CODE_W-1:0] dec_code_in,
  output logic      [efp_pkg::PRIM_W-1:0] dec_data_out,
  output logic                            dec_sbe_out,
  output logic                            dec_dbe_out
);

  logic [efp_pkg::CODE_W-1:0] enc_w;
  logic [efp_pkg::CODE_W-1:0] fix_w;
  logic [efp_pkg::PAR_N-1:0]  syn_w;
  logic                       ovr_w;

  // ---------------------------------------------------------------------------
  // encoder
  // ---------------------------------------------------------------------------
  always_comb begin
    enc_w = '0;
    for (int j = 1, k = 0; j < efp_pkg::CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        enc_w[j] = enc_data_in[k];
        k++;
      end
    end
    for (int i = 0; i < efp_pkg::PAR_N; i++) begin
      for (int j = 1; j < efp_pkg::CODE_W; j++) begin
        if (((j >> i) & 1) == 1 && j != (1 << i)) begin
          enc_w[1 << i] = enc_w[1 << i] ^ enc_w[j];
        end
      end
    end
    enc_w[0] = ^enc_w[efp_pkg::CODE_W-1:1];
    enc_code_out = enc_w;
  end

  // ---------------------------------------------------------------------------
  // decoder
  // ---------------------------------------------------------------------------
  always_comb begin
    syn_w = '0;
    for (int i = 0; i < efp_pkg::PAR_N; i++) begin
      for (int j = 1; j < efp_pkg::CODE_W; j++) begin
        if (((j >> i) & 1) == 1) begin
          syn_w[i] = syn_w[i] ^ dec_code_in[j];
        end
      end
    end
    ovr_w = ^dec_code_in;
    fix_w = dec_code_in;
    // odd overall parity: one flipped bit, syndrome points at it
    if (ovr_w && int'(syn_w) < efp_pkg::CODE_W) begin
      fix_w[syn_w] = ~fix_w[syn_w];
    end
    dec_sbe_out = ovr_w && int'(syn_w) < efp_pkg::CODE_W;
    dec_dbe_out = (!ovr_w && syn_w != '0) || (ovr_w && int'(syn_w) >= efp_pkg::CODE_W);
    dec_data_out = '0;
    for (int j = 1, k = 0; j < efp_pkg::CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        dec_data_out[k] = fix_w[j];
        k++;
      end
    end
  end

endmodule

// ===== test/efp_user_side.sv
// Purpose: user logic on the read side of the fifo, consuming lookahead words
// Assumes: common clock, requests change on the falling edge
// Notes:   mode 0 stops, 1 takes every word, 2 stalls at random, 3 reads blindly
`timescale 1ns/1ps
module efp_user_side (
  input  wire logic       sys_clk_in,
  input  wire logic       valid_in,
  input  wire logic [1:0] mode_in,
  output logic            rd_en_out
);
  integer seed = 13968;

  initial rd_en_out = 1'b0;

  // read request belongs to the common clock; flags never tied to a word
  always @(negedge sys_clk_in) begin
    case (mode_in)
      2'h1:    rd_en_out <= valid_in;
      2'h2:    rd_en_out <= valid_in && ($random(seed) % 2 != 0);
      2'h3:    rd_en_out <= 1'b1;
      default: rd_en_out <= 1'b0;
    endcase
  end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the ecc lookahead fifo
// Assumes: ecc and injection enabled, one primitive, inputs move on falling edge
// Notes:   expected words queued by the writer, checked when consumed
`timescale 1ns/1ps
module testbench;
  logic                       sys_clk_in = 1'b0;
  logic                       sys_rst_in = 1'b1;
  logic                       ce_in = 1'b1;
  logic [efp_pkg::DATA_W-1:0] wr_data_in = 16'h0000;
  logic                       wr_en_in = 1'b0;
  logic                       inject_sbit_in = 1'b0;
  logic                       inject_dbit_in = 1'b0;
  logic                       full_out, almost_full_out, wr_ack_out, overflow_out;
  logic [efp_pkg::PTR_W-1:0]  wr_level_out;
  logic                       rd_en_in;
  logic [efp_pkg::DATA_W-1:0] rd_data_out;
  logic                       valid_out, empty_out, almost_empty_out, underflow_out;
  logic                       sbit_err_out, dbit_err_out;
  logic [1:0]                 mode = 2'h0;
  logic [16:0]                exp_q[$];
  logic [16:0]                e;
  logic                       sb_seen, db_seen;
  integer                     seed = 13968;
  integer                     mismatches = 0;
  integer                     checks = 0;
  integer                     n;

  always #5 sys_clk_in = ~sys_clk_in;

  efp_fifo uut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .inject_sbit_in(inject_sbit_in),
    .inject_dbit_in(inject_dbit_in), .full_out(full_out),
    .almost_full_out(almost_full_out), .wr_ack_out(wr_ack_out),
    .overflow_out(overflow_out), .wr_level_out(wr_level_out), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .valid_out(valid_out), .empty_out(empty_out),
    .almost_empty_out(almost_empty_out), .underflow_out(underflow_out),
    .sbit_err_out(sbit_err_out), .dbit_err_out(dbit_err_out)
  );

  efp_user_side sink (
    .sys_clk_in(sys_clk_in), .valid_in(valid_out), .mode_in(mode), .rd_en_out(rd_en_in)
  );

  // ---------------------------------------------------------------------------
  // compare and finish
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [15:0] d, input logic sb, input logic db, input logic chk);
    @(negedge sys_clk_in);
    wr_en_in = 1'b1;
    wr_data_in = d;
    inject_sbit_in = sb;
    inject_dbit_in = db;
    if (full_out === 1'b0) exp_q.push_back({chk, d});
    @(posedge sys_clk_in);
  endtask

  task automatic idle();
    @(negedge sys_clk_in);
    wr_en_in = 1'b0;
    inject_sbit_in = 1'b0;
    inject_dbit_in = 1'b0;
  endtask

  task automatic do_reset();
    @(negedge sys_clk_in);
    sys_rst_in = 1'b1;
    exp_q.delete();
    repeat (5) @(negedge sys_clk_in);
    check(valid_out, 1'b0);
    check({empty_out, almost_empty_out, full_out, almost_full_out}, 4'hc);
    check(wr_level_out, 10'h000);
    sys_rst_in = 1'b0;
  endtask

  task automatic drain();
    mode = 2'h1;
    for (n = 0; n < 3000 && (exp_q.size() != 0 || empty_out !== 1'b1); n++) begin
      @(negedge sys_clk_in);
    end
    check(exp_q.size(), 0);
    mode = 2'h0;
  endtask

  // ---------------------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (sbit_err_out === 1'b1) sb_seen <= 1'b1;
    if (dbit_err_out === 1'b1) db_seen <= 1'b1;
    if (sys_rst_in === 1'b0 && ce_in && valid_out === 1'b1 && rd_en_in === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        e = exp_q.pop_front();
        if (e[16]) check(rd_data_out, e[15:0]);
      end
    end
  end

  initial begin
    #400000;
    mismatches++;
    test_done();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    do_reset();
    wr(16'ha5c3, 1'b0, 1'b0, 1'b1);
    idle();
    check({wr_ack_out, wr_level_out}, 11'h401);
    repeat (3) @(negedge sys_clk_in);
    check(valid_out, 1'b0);
    @(negedge sys_clk_in);
    check({valid_out, empty_out}, 2'h2);
    check(rd_data_out, 16'ha5c3);
    sys_rst_in = 1'b1;
    @(negedge sys_clk_in);
    check(rd_data_out, 16'ha5c3);
    do_reset();
    // clock enable low: nothing accepted
    @(negedge sys_clk_in);
    ce_in = 1'b0;
    wr_en_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    check({wr_ack_out, wr_level_out}, 11'h000);
    wr_en_in = 1'b0;
    ce_in = 1'b1;
    // random traffic with a stalling reader
    mode = 2'h2;
    for (int i = 0; i < 300; i++) begin
      if ($random(seed) % 3 != 0) wr($random(seed), 1'b0, 1'b0, 1'b1);
      else idle();
    end
    idle();
    drain();
    // fill until refused, then overflow
    for (n = 0; n < 600 && full_out !== 1'b1; n++) wr($random(seed), 1'b0, 1'b0, 1'b1);
    wr(16'h1234, 1'b0, 1'b0, 1'b1);
    idle();
    check({full_out, almost_full_out, overflow_out, wr_ack_out}, 4'he);
    check(wr_level_out, efp_pkg::DEPTH_LVL);
    drain();
    mode = 2'h3;
    repeat (2) @(negedge sys_clk_in);
    check({underflow_out, valid_out}, 2'h2);
    mode = 2'h0;
    // injection: single, double, both; restart after double
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wr(16'h0f0f, 1'b0, 1'b0, 1'b1);
      idle();
      for (n = 0; n < 20 && valid_out !== 1'b1; n++) @(negedge sys_clk_in);
      sb_seen = 1'b0;
      db_seen = 1'b0;
      wr(16'h3c96, k != 1, k != 0, k == 0);
      wr(16'h7e01, 1'b0, 1'b0, k == 0);
      idle();
      drain();
      repeat (3) @(negedge sys_clk_in);
      check({sb_seen, db_seen}, {k == 0, k != 0});
    end
    // double error seen: reset and restart the transfer
    do_reset();
    wr(16'h5aa5, 1'b0, 1'b0, 1'b1);
    idle();
    drain();
    test_done();
  end
endmodule
